// ===== logic/bib_bank_ctl.sv
// Controller end: Avalon-MM slave registers that drive the bank link.
// Assumes software is an Avalon-MM master on the same system clock.
`timescale 1ns/100ps
module bib_bank_ctl #(
  parameter bit RST_ACTIVE_HIGH = 1'b1
) (
  input wire logic i_clk_sys, // System clock, 125 MHz
  input wire logic i_srst, // Synchronous reset, active high
  input wire logic [1:0] i_avs_address, // Word address
  input wire logic i_avs_read, // Read strobe
  input wire logic i_avs_write, // Write strobe
  input wire logic [31:0] i_avs_writedata, // Write data
  output logic [31:0] o_avs_readdata, // Read data
  output logic o_avs_waitrequest, // Low for the answer cycle
  bib_link_if.host lnk // Link to the bank
);
  typedef enum logic [1:0] {H_IDLE, H_REQ, H_RST} bib_host_state_t;

  // ********************************************************
  // Avalon slave and link sequencer
  // ********************************************************
  logic take;
  logic [31:0] status;
  logic reset_ok;
  bib_host_state_t state_ff, nxt_state;
  logic wait_ff, nxt_wait;
  logic [31:0] rd_ff, nxt_rd;
  logic [lnk.SEL_W-1:0] sel_ff, nxt_sel;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [31:0] rdata_ff, nxt_rdata;
  logic req_ff, nxt_req;
  logic wr_ff, nxt_wr;
  logic shut_ff, nxt_shut;
  logic rest_ff, nxt_rest;
  logic rst_ff, nxt_rst;
  logic refused_ff, nxt_refused;
  logic [7:0] cnt_ff, nxt_cnt;

  // Write acts at the edge where waitrequest is seen low
  assign take = i_avs_write && !wait_ff && i_avs_address == bib_pkg::REG_CTRL;
  // Reset only when shut or idle
  assign reset_ok = lnk.in_shutdown || !lnk.cfg_busy;

  always_comb begin
    status = bib_pkg::WORD_ZERO;
    status[bib_pkg::STAT_BUSY] = (state_ff != H_IDLE);
    status[bib_pkg::STAT_SHUT] = lnk.in_shutdown;
    status[bib_pkg::STAT_CFG_BUSY] = lnk.cfg_busy;
    status[bib_pkg::STAT_IN_RESET] = rst_ff;
    status[bib_pkg::STAT_REFUSED] = refused_ff;
  end

  // Next values for slave and link
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = !((i_avs_read || i_avs_write) && wait_ff);
    nxt_rd = rd_ff;
    nxt_sel = sel_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_req = req_ff;
    nxt_wr = wr_ff;
    nxt_shut = 1'b0;
    nxt_rest = 1'b0;
    nxt_rst = rst_ff;
    nxt_refused = refused_ff;
    nxt_cnt = cnt_ff;
    // Read data is ready by the answer cycle
    if (i_avs_read && wait_ff) begin
      unique case (i_avs_address)
        bib_pkg::REG_CTRL: nxt_rd = bib_pkg::WORD_ZERO;
        bib_pkg::REG_SEL: nxt_rd = 32'(sel_ff);
        bib_pkg::REG_DATA: nxt_rd = rdata_ff;
        bib_pkg::REG_STATUS: nxt_rd = status;
      endcase
    end
    if (i_avs_write && !wait_ff) begin
      if (i_avs_address == bib_pkg::REG_SEL) begin
        nxt_sel = i_avs_writedata[lnk.SEL_W-1:0];
      end
      if (i_avs_address == bib_pkg::REG_DATA) begin
        nxt_wdata = i_avs_writedata;
      end
    end
    // Refused flag clears on a control write, a new refusal wins
    if (take) begin
      nxt_refused = 1'b0;
    end
    unique case (state_ff)
      H_IDLE: begin
        if (take && i_avs_writedata[bib_pkg::CTRL_RESET]) begin
          if (reset_ok) begin
            nxt_rst = 1'b1;
            nxt_cnt = bib_pkg::RESET_HOLD_CNT;
            nxt_state = H_RST;
          end else begin
            nxt_refused = 1'b1;
          end
        end else if (take) begin
          nxt_shut = i_avs_writedata[bib_pkg::CTRL_SHUTDOWN];
          nxt_rest = i_avs_writedata[bib_pkg::CTRL_RESTART];
          if (i_avs_writedata[bib_pkg::CTRL_GO]) begin
            nxt_req = 1'b1;
            nxt_wr = i_avs_writedata[bib_pkg::CTRL_WRITE];
            nxt_state = H_REQ;
          end
        end
      end
      H_REQ: begin
        if (take) begin
          nxt_refused = 1'b1;
        end
        if (lnk.ack) begin
          nxt_req = 1'b0;
          nxt_rdata = lnk.rdata;
          nxt_state = H_IDLE;
        end
      end
      H_RST: begin
        if (take) begin
          nxt_refused = 1'b1;
        end
        if (cnt_ff == 8'h00) begin
          nxt_rst = 1'b0;
          nxt_state = H_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
    endcase
  end

  // Registers; own reset also holds the bank in reset
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_ff <= H_RST;
      wait_ff <= 1'b1;
      rd_ff <= bib_pkg::WORD_ZERO;
      sel_ff <= '0;
      wdata_ff <= bib_pkg::WORD_ZERO;
      rdata_ff <= bib_pkg::WORD_ZERO;
      req_ff <= 1'b0;
      wr_ff <= 1'b0;
      shut_ff <= 1'b0;
      rest_ff <= 1'b0;
      rst_ff <= 1'b1;
      refused_ff <= 1'b0;
      cnt_ff <= bib_pkg::RESET_HOLD_CNT;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      rd_ff <= nxt_rd;
      sel_ff <= nxt_sel;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      req_ff <= nxt_req;
      wr_ff <= nxt_wr;
      shut_ff <= nxt_shut;
      rest_ff <= nxt_rest;
      rst_ff <= nxt_rst;
      refused_ff <= nxt_refused;
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_avs_readdata = rd_ff;
  assign o_avs_waitrequest = wait_ff;
  assign lnk.rst_main = rst_ff ? RST_ACTIVE_HIGH : !RST_ACTIVE_HIGH;
  assign lnk.rst_cfg = rst_ff ? RST_ACTIVE_HIGH : !RST_ACTIVE_HIGH;
  assign lnk.req = req_ff;
  assign lnk.wr = wr_ff;
  assign lnk.sel = sel_ff;
  assign lnk.wdata = wdata_ff;
  assign lnk.cmd_shutdown = shut_ff;
  assign lnk.cmd_restart = rest_ff;
endmodule

// ===== logic/bib_bank_dev.sv
// Bitstream information bank of one socket manager, with its loader.
// Assumes the link partner holds req until ack and pulses commands.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
module bib_bank_dev #(
  parameter int ROWS = 4,
  parameter bit DUAL_FAMILY = 1'b1,
  parameter bit RST_ACTIVE_HIGH = 1'b1,
  parameter int SYNC_STAGES = 2
) (
  input wire logic i_clk_sys, // Main clock, 125 MHz
  input wire logic i_clk_cfg, // Config port clock
  bib_link_if.dev lnk, // Link to the controller
  input wire logic i_load_req, // Load request pulse
  input wire logic [bib_pkg::ROW_PTR_W-1:0] i_module_bitstream_pointer, // Row to load
  output logic o_cfg_active, // Config port transfer running
  output logic [31:0] o_cfg_addr // Current library byte address
);
  localparam int ROW_W = $clog2(ROWS);

  // ********************************************************
  // Elaboration checks
  // ********************************************************
  // Refused at elaboration, not at run time
  if (ROWS < 2 || ROWS > 65536) begin : g_bad_rows
    $error("ROWS out of range");
  end
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES below 2");
  end
  if (lnk.SEL_W != ROW_W + bib_pkg::SEL_FIELD_W) begin : g_bad_sel
    $error("link select width mismatch");
  end

  typedef enum logic [1:0] {ST_ACTIVE, ST_DRAIN, ST_SHUT} bib_mgr_state_t;

  // ********************************************************
  // Main domain
  // ********************************************************
  logic rst_m;
  logic [ROW_W-1:0] row;
  logic [1:0] fld;
  logic row_ok;
  logic acc;
  logic done_seen;
  bib_mgr_state_t state_ff, nxt_state;
  logic ack_ff, nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;
  logic in_shut_ff, nxt_in_shut;
  logic busy_ff, nxt_busy;
  logic req_tgl_ff, nxt_req_tgl;
  logic [31:0] ld_addr_ff, nxt_ld_addr;
  logic [31:0] ld_size_ff, nxt_ld_size;
  logic ident_ff [ROWS];
  logic nxt_ident [ROWS];
  logic [31:0] addr_ff [ROWS];
  logic [31:0] nxt_addr [ROWS];
  logic [31:0] size_ff [ROWS];
  logic [31:0] nxt_size [ROWS];
  logic [SYNC_STAGES-1:0] done_sync_ff;
  logic done_prev_ff;
  logic done_tgl_ff;

  assign rst_m = (lnk.rst_main == RST_ACTIVE_HIGH);
  assign row = lnk.sel[lnk.SEL_W-1:bib_pkg::SEL_FIELD_W];
  assign fld = lnk.sel[bib_pkg::SEL_FIELD_W-1:0];
  assign row_ok = (int'(row) < ROWS);
  // Accept each held request once
  assign acc = lnk.req && !ack_ff;
  // Only the last stage is compared
  assign done_seen = done_sync_ff[SYNC_STAGES-1] ^ done_prev_ff;

  // Next state of bank, manager and loader
  always_comb begin
    nxt_state = state_ff;
    nxt_ack = acc;
    nxt_rdata = rdata_ff;
    nxt_busy = busy_ff;
    nxt_req_tgl = req_tgl_ff;
    nxt_ld_addr = ld_addr_ff;
    nxt_ld_size = ld_size_ff;
    nxt_ident = ident_ff;
    nxt_addr = addr_ff;
    nxt_size = size_ff;
    unique case (state_ff)
      ST_ACTIVE: begin
        if (lnk.cmd_shutdown) begin
          nxt_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!busy_ff) begin
          nxt_state = ST_SHUT;
        end
      end
      ST_SHUT: begin
        if (lnk.cmd_restart) begin
          nxt_state = ST_ACTIVE;
        end
      end
    endcase
    if (acc) begin
      nxt_rdata = bib_pkg::WORD_ZERO;
      if (state_ff == ST_SHUT && row_ok) begin
        unique case (fld)
          bib_pkg::SEL_IDENT: begin
            if (DUAL_FAMILY) begin
              nxt_rdata[bib_pkg::IDENT_BIT] = ident_ff[row];
              if (lnk.wr) begin
                nxt_ident[row] = lnk.wdata[bib_pkg::IDENT_BIT];
              end
            end
          end
          bib_pkg::SEL_ADDR: begin
            nxt_rdata = addr_ff[row];
            if (lnk.wr) begin
              nxt_addr[row] = lnk.wdata;
            end
          end
          bib_pkg::SEL_SIZE: begin
            nxt_rdata = size_ff[row];
            if (lnk.wr) begin
              nxt_size[row] = lnk.wdata;
            end
          end
          default: begin
            nxt_rdata = bib_pkg::WORD_ZERO;
          end
        endcase
      end
    end
    if (done_seen) begin
      nxt_busy = 1'b0;
    end
    if (i_load_req && state_ff == ST_ACTIVE && !busy_ff && !lnk.cmd_shutdown
        && int'(i_module_bitstream_pointer) < ROWS) begin
      nxt_ld_addr = addr_ff[i_module_bitstream_pointer[ROW_W-1:0]];
      nxt_ld_size = size_ff[i_module_bitstream_pointer[ROW_W-1:0]];
      nxt_busy = 1'b1;
      nxt_req_tgl = !req_tgl_ff;
    end
    nxt_in_shut = (nxt_state == ST_SHUT);
  end

  // Main domain registers
  always_ff @(posedge i_clk_sys) begin
    if (rst_m) begin
      state_ff <= ST_ACTIVE;
      ack_ff <= 1'b0;
      rdata_ff <= bib_pkg::WORD_ZERO;
      in_shut_ff <= 1'b0;
      busy_ff <= 1'b0;
      req_tgl_ff <= 1'b0;
      ld_addr_ff <= bib_pkg::WORD_ZERO;
      ld_size_ff <= bib_pkg::WORD_ZERO;
      done_sync_ff <= '0;
      done_prev_ff <= 1'b0;
      for (int i = 0; i < ROWS; i++) begin
        ident_ff[i] <= 1'b0;
        addr_ff[i] <= bib_pkg::WORD_ZERO;
        size_ff[i] <= bib_pkg::WORD_ZERO;
      end
    end else begin
      state_ff <= nxt_state;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      in_shut_ff <= nxt_in_shut;
      busy_ff <= nxt_busy;
      req_tgl_ff <= nxt_req_tgl;
      ld_addr_ff <= nxt_ld_addr;
      ld_size_ff <= nxt_ld_size;
      done_sync_ff <= {done_sync_ff[SYNC_STAGES-2:0], done_tgl_ff};
      done_prev_ff <= done_sync_ff[SYNC_STAGES-1];
      ident_ff <= nxt_ident;
      addr_ff <= nxt_addr;
      size_ff <= nxt_size;
    end
  end

  assign lnk.ack = ack_ff;
  assign lnk.rdata = rdata_ff;
  assign lnk.in_shutdown = in_shut_ff;
  assign lnk.cfg_busy = busy_ff;

  // ********************************************************
  // Config port domain
  // ********************************************************
  logic [SYNC_STAGES-1:0] rst_sync_ff;
  logic [SYNC_STAGES-1:0] req_sync_ff;
  logic req_prev_ff;
  logic rst_c;
  logic req_seen;
  logic act_ff, nxt_act;
  logic [31:0] cnt_ff, nxt_cnt;
  logic [31:0] caddr_ff, nxt_caddr;
  logic nxt_done_tgl;

  // Reset comes from the main domain, so it is synchronised too
  assign rst_c = rst_sync_ff[SYNC_STAGES-1];
  assign req_seen = req_sync_ff[SYNC_STAGES-1] ^ req_prev_ff;

  always_comb begin
    nxt_act = act_ff;
    nxt_cnt = cnt_ff;
    nxt_caddr = caddr_ff;
    nxt_done_tgl = done_tgl_ff;
    if (req_seen) begin
      // Load words are stable while main side is busy
      nxt_act = 1'b1;
      nxt_cnt = ld_size_ff;
      nxt_caddr = ld_addr_ff;
    end else if (act_ff) begin
      // A short tail still costs one whole beat
      if (cnt_ff <= bib_pkg::BYTES_PER_BEAT) begin
        nxt_act = 1'b0;
        nxt_cnt = bib_pkg::WORD_ZERO;
        nxt_done_tgl = !done_tgl_ff;
      end else begin
        nxt_cnt = cnt_ff - bib_pkg::BYTES_PER_BEAT;
        nxt_caddr = caddr_ff + bib_pkg::BYTES_PER_BEAT;
      end
    end
  end

  // Config domain synchroniser for reset, no reset of its own
  always_ff @(posedge i_clk_cfg) begin
    rst_sync_ff <= {rst_sync_ff[SYNC_STAGES-2:0], (lnk.rst_cfg == RST_ACTIVE_HIGH)};
  end

  // Config domain registers
  always_ff @(posedge i_clk_cfg) begin
    if (rst_c) begin
      req_sync_ff <= '0;
      req_prev_ff <= 1'b0;
      act_ff <= 1'b0;
      cnt_ff <= bib_pkg::WORD_ZERO;
      caddr_ff <= bib_pkg::WORD_ZERO;
      done_tgl_ff <= 1'b0;
    end else begin
      req_sync_ff <= {req_sync_ff[SYNC_STAGES-2:0], req_tgl_ff};
      req_prev_ff <= req_sync_ff[SYNC_STAGES-1];
      act_ff <= nxt_act;
      cnt_ff <= nxt_cnt;
      caddr_ff <= nxt_caddr;
      done_tgl_ff <= nxt_done_tgl;
    end
  end

  assign o_cfg_active = act_ff;
  assign o_cfg_addr = caddr_ff;
endmodule

// ===== logic/bib_link_if.sv
// Link between the bank controller and the bitstream information bank.
// Assumes both ends are clocked by the same system clock.
`timescale 1ns/100ps
interface bib_link_if #(
  parameter int SEL_W = 4
);
  logic rst_main; // Main domain reset, configurable polarity
  logic rst_cfg; // Config port domain reset, same polarity
  logic req; // Register access request, held until ack
  logic wr; // Access direction, 1 = write
  logic [SEL_W-1:0] sel; // Register select, row above field
  logic [31:0] wdata; // Write data
  logic ack; // One-cycle answer pulse
  logic [31:0] rdata; // Read data, valid with ack
  logic cmd_shutdown; // One-cycle shutdown command
  logic cmd_restart; // One-cycle restart command
  logic in_shutdown; // Manager is in shutdown
  logic cfg_busy; // Load pending or transferring

  modport dev (
    input rst_main, rst_cfg, req, wr, sel, wdata, cmd_shutdown, cmd_restart,
    output ack, rdata, in_shutdown, cfg_busy
  );
  modport host (
    output rst_main, rst_cfg, req, wr, sel, wdata, cmd_shutdown, cmd_restart,
    input ack, rdata, in_shutdown, cfg_busy
  );
endinterface

// ===== logic/bib_pkg.sv
// Shared constants for the bitstream information bank and its controller.
// Assumes both ends run on the same 125 MHz system clock.
package bib_pkg;
  // ********************************************************
  // Bank register select, low two bits
  // ********************************************************
  localparam logic [1:0] SEL_IDENT = 2'h0;
  localparam logic [1:0] SEL_ADDR = 2'h1;
  localparam logic [1:0] SEL_SIZE = 2'h2;
  localparam int SEL_FIELD_W = 2;
  localparam int ROW_PTR_W = 16;
  localparam int IDENT_BIT = 0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] BYTES_PER_BEAT = 32'h0000_0004;

  // ********************************************************
  // Controller registers, Avalon word addresses
  // ********************************************************
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_SEL = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  // Control register bits
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_SHUTDOWN = 2;
  localparam int CTRL_RESTART = 3;
  localparam int CTRL_RESET = 4;
  // Status register bits
  localparam int STAT_BUSY = 0;
  localparam int STAT_SHUT = 1;
  localparam int STAT_CFG_BUSY = 2;
  localparam int STAT_IN_RESET = 3;
  localparam int STAT_REFUSED = 4;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int RESET_HOLD_NS = 32;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] RESET_HOLD_CNT = 8'(RESET_HOLD_CYC);
endpackage

// ===== tb/bib_link_assertions.sv
// Concurrent checks on the link between the bank controller and the bank.
// Assumes one system clock and an active-high main reset on the link.
`timescale 1ns/100ps
module bib_link_assertions #(
  parameter int SEL_W = 4
) (
  input wire logic i_clk_sys, // System clock
  input wire logic rst_main, // Bank main reset
  input wire logic rst_cfg, // Config port reset
  input wire logic req, // Access request
  input wire logic wr, // Access direction
  input wire logic [SEL_W-1:0] sel, // Register select
  input wire logic [31:0] wdata, // Write data
  input wire logic ack, // Answer pulse
  input wire logic [31:0] rdata, // Read data
  input wire logic cmd_shutdown, // Shutdown command pulse
  input wire logic cmd_restart, // Restart command pulse
  input wire logic in_shutdown, // Manager in shutdown
  input wire logic cfg_busy // Load pending or running
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (rst_main);

  // ********************************************************
  // Helper state
  // ********************************************************
  logic pend_ff;
  logic nxt_pend;

  // Shutdown asked for and not yet reached; entry without it is a fault
  always_comb begin
    nxt_pend = pend_ff;
    if (cmd_shutdown && !in_shutdown) nxt_pend = 1'b1;
    if (in_shutdown) nxt_pend = 1'b0;
  end

  // Registers the pending flag
  always_ff @(posedge i_clk_sys) begin
    if (rst_main) pend_ff <= 1'b0;
    else pend_ff <= nxt_pend;
  end

  // ********************************************************
  // Properties
  // ********************************************************
  // Config reset never stands alone, or one domain could lock up
  resets_paired_a: assert property (!rst_cfg)
    else $error("config reset asserted without main reset");
  ack_answers_req_a: assert property ($rose(req) |=> ack)
    else $error("no answer one cycle after request");
  ack_one_cycle_a: assert property (ack |=> !ack && !req)
    else $error("answer or request held past answer cycle");
  req_held_a: assert property (req && !ack |=> req && $stable(sel) && $stable(wr) && $stable(wdata))
    else $error("request changed before its answer");
  closed_reads_zero_a: assert property (ack && !wr && !$past(in_shutdown) |-> rdata == bib_pkg::WORD_ZERO)
    else $error("read outside shutdown returned data");
  ident_reserved_a: assert property (ack && !wr && sel[1:0] == bib_pkg::SEL_IDENT |-> rdata[31:1] == 31'h0000_0000)
    else $error("identifier reserved bits not zero");
  field_unused_a: assert property (ack && !wr && sel[1:0] == 2'h3 |-> rdata == bib_pkg::WORD_ZERO)
    else $error("unused field select returned data");
  shut_entry_a: assert property ($rose(in_shutdown) |-> pend_ff && $past(!cfg_busy))
    else $error("shutdown entered without command or while busy");
  restart_leaves_a: assert property (in_shutdown && cmd_restart |-> ##[1:2] !in_shutdown)
    else $error("restart did not leave shutdown");
  shut_exit_a: assert property ($fell(in_shutdown) |-> $past(cmd_restart) || $past(cmd_restart, 2))
    else $error("shutdown left without restart");
endmodule

// ===== tb/tb_bitstream_info_register_bank.sv
// Bench for the bank and its controller, joined through the link interface.
// Assumes a second pair built for the single-bitstream family, fed alike.
`timescale 1ns/100ps
module tb_bitstream_info_register_bank;
  logic i_clk_sys = 1'b0;
  logic clk_cfg = 1'b0;
  logic i_srst = 1'b1;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] rd_a, rd_b, q_a, q_b, cfg_addr;
  logic wait_a, wait_b, cfg_active;
  logic load_req = 1'b0;
  logic [15:0] load_ptr = 16'h0000;
  int failures = 0;
  int comparisons = 0;

  // Config clock unrelated to the system clock, running through reset
  always #4 i_clk_sys = ~i_clk_sys;
  always #5.3 clk_cfg = ~clk_cfg;

  bib_link_if #(.SEL_W(4)) lnk_a ();
  bib_link_if #(.SEL_W(4)) lnk_b ();
  bib_bank_ctl bib_bank_ctl_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(rd_a), .o_avs_waitrequest(wait_a),
    .lnk(lnk_a));
  bib_bank_dev bib_bank_dev_i (.i_clk_sys(i_clk_sys), .i_clk_cfg(clk_cfg), .lnk(lnk_a),
    .i_load_req(load_req), .i_module_bitstream_pointer(load_ptr),
    .o_cfg_active(cfg_active), .o_cfg_addr(cfg_addr));
  // Single family pair sees the same bus traffic and load requests
  bib_bank_ctl bib_bank_ctl_sgl_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(rd_b), .o_avs_waitrequest(wait_b),
    .lnk(lnk_b));
  bib_bank_dev #(.DUAL_FAMILY(1'b0)) bib_bank_dev_sgl_i (.i_clk_sys(i_clk_sys),
    .i_clk_cfg(clk_cfg), .lnk(lnk_b), .i_load_req(load_req), .i_module_bitstream_pointer(load_ptr),
    .o_cfg_active(), .o_cfg_addr());
  bib_link_assertions #(.SEL_W(4)) bib_link_assertions_i (.i_clk_sys(i_clk_sys),
    .rst_main(lnk_a.rst_main), .rst_cfg(lnk_a.rst_cfg), .req(lnk_a.req), .wr(lnk_a.wr),
    .sel(lnk_a.sel), .wdata(lnk_a.wdata), .ack(lnk_a.ack), .rdata(lnk_a.rdata),
    .cmd_shutdown(lnk_a.cmd_shutdown), .cmd_restart(lnk_a.cmd_restart),
    .in_shutdown(lnk_a.in_shutdown), .cfg_busy(lnk_a.cfg_busy));

  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (wait_a !== 1'b0 && n < 40);
    check("waitrequest", {31'h0000_0000, wait_a}, 32'h0000_0000);
    q_a = rd_a;
    q_b = rd_b;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  // Polls a status bit until it shows the wanted level
  task automatic poll(input int bitn, input logic val);
    int n;
    n = 0;
    do begin
      av(1'b0, bib_pkg::REG_STATUS, 32'h0000_0000);
      n++;
    end while (q_a[bitn] !== val && n < 200);
    check("status bit", {31'h0000_0000, q_a[bitn]}, {31'h0000_0000, val});
  endtask

  task automatic bank(input int r, input int f, input logic w, input logic [31:0] d);
    av(1'b1, bib_pkg::REG_SEL, 32'(r * 4 + f));
    if (w) av(1'b1, bib_pkg::REG_DATA, d);
    av(1'b1, bib_pkg::REG_CTRL, w ? 32'h0000_0003 : 32'h0000_0001); // Go, plus write
    poll(bib_pkg::STAT_BUSY, 1'b0);
    av(1'b0, bib_pkg::REG_DATA, 32'h0000_0000);
  endtask

  task automatic cmd(input int bitn, input logic shut);
    av(1'b1, bib_pkg::REG_CTRL, 32'h0000_0001 << bitn);
    poll(bib_pkg::STAT_SHUT, shut);
  endtask

  function automatic logic [31:0] row_addr(input int r);
    return 32'hF0F0_0000 + 32'(r * 16);
  endfunction

  // ********************************************************
  // Scenarios
  // ********************************************************
  // Bank closed while active: writes dropped, reads zero
  task automatic t_closed();
    bank(1, 1, 1'b1, 32'h5A5A_5A5A);
    check("closed read", q_a, 32'h0000_0000);
    cmd(bib_pkg::CTRL_SHUTDOWN, 1'b1);
    bank(1, 1, 1'b0, 32'h0000_0000);
    check("dropped write", q_a, 32'h0000_0000);
  endtask

  // Every row and field written and read back in shutdown
  task automatic t_rows();
    for (int r = 0; r < 4; r++) begin
      bank(r, 0, 1'b1, 32'hFFFF_FFFE | 32'(r % 2));
      bank(r, 1, 1'b1, row_addr(r));
      bank(r, 2, 1'b1, 32'(r * 4 + 5));
    end
    for (int r = 0; r < 4; r++) begin
      bank(r, 0, 1'b0, 32'h0000_0000);
      check("ident dual", q_a, 32'(r % 2));
      check("ident single", q_b, 32'h0000_0000);
      bank(r, 1, 1'b0, 32'h0000_0000);
      check("address", q_a, row_addr(r));
      check("address single", q_b, row_addr(r));
      bank(r, 2, 1'b0, 32'h0000_0000);
      check("size", q_a, 32'(r * 4 + 5));
    end
    bank(2, 3, 1'b0, 32'h0000_0000);
    check("unused field", q_a, 32'h0000_0000);
  endtask

  // Restart closes the bank again; a load then runs from row 2
  task automatic t_load();
    int n;
    cmd(bib_pkg::CTRL_RESTART, 1'b0);
    bank(2, 1, 1'b1, 32'h1234_5678);
    bank(2, 1, 1'b0, 32'h0000_0000);
    check("closed after restart", q_a, 32'h0000_0000);
    @(posedge i_clk_sys);
    load_req <= 1'b1;
    load_ptr <= 16'h0002;
    @(posedge i_clk_sys);
    load_req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_cfg);
      n++;
    end while (cfg_active !== 1'b1 && n < 50);
    check("first beat address", cfg_addr, row_addr(2));
    n = 1;
    forever begin
      @(posedge clk_cfg);
      if (cfg_active !== 1'b1 || n > 50) break;
      n++;
    end
    check("beat count", 32'(n), 32'h0000_0004);
    poll(bib_pkg::STAT_CFG_BUSY, 1'b0);
    cmd(bib_pkg::CTRL_SHUTDOWN, 1'b1);
    bank(2, 1, 1'b0, 32'h0000_0000);
    check("kept address", q_a, row_addr(2));
  endtask

  // Mid-run reset from shutdown clears both domains; commands in the hold are refused
  task automatic t_reset();
    av(1'b1, bib_pkg::REG_CTRL, 32'h0000_0001 << bib_pkg::CTRL_RESET);
    av(1'b1, bib_pkg::REG_CTRL, 32'h0000_0001);
    poll(bib_pkg::STAT_IN_RESET, 1'b0);
    check("refused in reset", {31'h0000_0000, q_a[bib_pkg::STAT_REFUSED]}, 32'h0000_0001);
    check("config reset", cfg_addr, 32'h0000_0000);
    cmd(bib_pkg::CTRL_SHUTDOWN, 1'b1);
    bank(2, 1, 1'b0, 32'h0000_0000);
    check("address after reset", q_a, 32'h0000_0000);
  endtask

  // ********************************************************
  // Main sequence and watchdog
  // ********************************************************
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    @(posedge i_clk_sys);
    poll(bib_pkg::STAT_IN_RESET, 1'b0);
    t_closed();
    t_rows();
    t_load();
    t_reset();
    finish_test();
  end

  // Whole run takes under a thousand cycles; this is 50,000 cycles, far beyond it
  initial begin
    #400_000;
    failures++;
    finish_test();
  end
endmodule
